// file: hw/extended_interrupt_status.sv
// Group-one interrupt status register with mask, direct test mode and pin routing.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Writing one clears a status bit except bits 1 and 2; zero leaves it.
// - Power-up and software reset clear every bit to zero except bit 1, which follows the group-zero input.
// - With the direct test bit set, software reads and writes the event bits and bit 2, but not bit 1.
// - Bit 1 reads one while any group-zero status bit is set.
// - Bit 2 reads one while any bit of this register other than bits 1 and 2 is set.
// - Bit 3 sets on a verified asynchronous bulk receive packet.
// - Bit 4 sets on a verified isochronous bulk receive packet.
// - Bit 6 sets on a verified video receive packet.
// - Bit 8 sets when the video release time is reached.
// - Bit 10 sets on an illegal host FIFO access; cause code kept elsewhere.
// - Bit 11 sets when an access starts before a write finishes.
// - Bit 12 sets on a partial purge from the asynchronous bulk receive FIFO.
// - Bit 13 sets on a seventeen-cycle handshake timeout.
// - Bit 14 sets on a partial purge from the isochronous bulk receive FIFO.
// - Bit 16 sets on a partial video packet purge.
// - Bits 17 and 18 set on asynchronous control FIFO confirm and purge.
// - Bits 19 and 20 set on broadcast control FIFO confirm and purge.
// - Bits 21 and 22 set on self-ID period end and self-ID purge.
// - Bit 24 sets when a host FIFO access is blocked by a busier transfer.
// - Bit 25 sets on a premature isochronous go event.
// - Bits 26 and 31 set on transmit and receive block count errors.
// - Bits 29 and 30 set on bulk asynchronous transmit success and failure.
// - A status bit reaches the interrupt only while its mask bit is one.
// - Mask bit 2 decides whether group-one status drives the interrupt pin.
module extended_interrupt_status #(
  parameter int ADDR_W = group1_irq_pkg::ADDR_W
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic soft_rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire group1_irq_pkg::event_type events,
  input wire logic group0_pending,
  output logic group1_irq
);

  logic [31:0] status_q;
  logic [31:0] status_d;
  logic [31:0] mask_q;
  logic [31:0] mask_d;
  logic [31:0] diagnostics_q;
  logic [31:0] diagnostics_d;
  logic sum1_test_q;
  logic sum1_test_d;
  logic [31:0] rdata_d;
  logic irq_d;

  // Address decode for the three registers.
  wire logic hit_status = reg_addr == ADDR_W'(group1_irq_pkg::STATUS_OFS);
  wire logic hit_mask = reg_addr == ADDR_W'(group1_irq_pkg::MASK_OFS);
  wire logic hit_diagnostics = reg_addr == ADDR_W'(group1_irq_pkg::DIAGNOSTICS_OFS);
  wire logic wr_status = reg_wr && hit_status;
  wire logic wr_mask = reg_wr && hit_mask;
  wire logic wr_diagnostics = reg_wr && hit_diagnostics;

  // Direct test mode enable from the diagnostics register.
  wire logic test_mode = diagnostics_q[group1_irq_pkg::DIRECT_TEST_BIT];

  // Event pulses restricted to the positions that hardware may set.
  wire logic [31:0] event_vec = 32'(events) & group1_irq_pkg::EVENT_BITS;

  // Write-one-to-clear vector; only live outside test mode.
  wire logic [31:0] clear_vec = (wr_status && !test_mode) ?
    (reg_wdata & group1_irq_pkg::EVENT_BITS) : 32'h0000_0000;

  // In test mode a write loads the event bits directly.
  wire logic [31:0] load_vec = reg_wdata & group1_irq_pkg::EVENT_BITS;

  // Summary bits. Bit 2 follows the stored flags; test mode may override it.
  wire logic sum1_live = |status_q;
  wire logic sum1_view = test_mode ? sum1_test_q : sum1_live;
  wire logic sum0_view = group0_pending;

  // Status as software sees it: stored flags plus the two summaries; bit 2 is writable in test mode.
  wire logic [31:0] status_view = status_q
    | (32'(sum0_view) << group1_irq_pkg::GRP0_SUM_BIT)
    | (32'(sum1_view) << group1_irq_pkg::GRP1_SUM_BIT);

  // Masked flags that may raise the interrupt.
  wire logic [31:0] enabled_vec = status_q & mask_q;
  wire logic route_on = mask_q[group1_irq_pkg::PIN_ROUTE_BIT];

  // Next value of the status flags.
  // An event in the same cycle as its clear wins, so no event is lost.
  always_comb begin
    if (soft_rst) begin
      status_d = group1_irq_pkg::STATUS_RST;
    end else if (wr_status && test_mode) begin
      status_d = load_vec | event_vec;
    end else begin
      status_d = (status_q & ~clear_vec) | event_vec;
    end
  end

  // Next value of the summary override used only in test mode.
  always_comb begin
    if (soft_rst) begin
      sum1_test_d = 1'b0;
    end else if (wr_status && test_mode) begin
      sum1_test_d = reg_wdata[group1_irq_pkg::GRP1_SUM_BIT];
    end else begin
      sum1_test_d = sum1_test_q;
    end
  end

  // Mask and diagnostics registers keep only their defined bits.
  always_comb begin
    if (soft_rst) begin
      mask_d = group1_irq_pkg::MASK_RST;
      diagnostics_d = group1_irq_pkg::DIAGNOSTICS_RST;
    end else begin
      mask_d = wr_mask ? (reg_wdata & group1_irq_pkg::MASK_BITS) : mask_q;
      diagnostics_d = wr_diagnostics ? (reg_wdata & group1_irq_pkg::DIAGNOSTICS_BITS) : diagnostics_q;
    end
  end

  // Read mux; unmapped addresses and idle cycles return zero.
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (reg_rd) begin
      if (hit_status) begin
        rdata_d = status_view;
      end else if (hit_mask) begin
        rdata_d = mask_q;
      end else if (hit_diagnostics) begin
        rdata_d = diagnostics_q;
      end else begin
        rdata_d = 32'h0000_0000;
      end
    end
  end

  // The pin is driven only when routing is on and an enabled flag is up.
  assign irq_d = route_on && (|enabled_vec) && !soft_rst;

  // Register state.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status_q <= group1_irq_pkg::STATUS_RST;
      mask_q <= group1_irq_pkg::MASK_RST;
      diagnostics_q <= group1_irq_pkg::DIAGNOSTICS_RST;
      sum1_test_q <= 1'b0;
    end else begin
      status_q <= status_d;
      mask_q <= mask_d;
      diagnostics_q <= diagnostics_d;
      sum1_test_q <= sum1_test_d;
    end
  end

  // Registered outputs, so the read data stand exactly one cycle after the strobe.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
      group1_irq <= 1'b0;
    end else begin
      reg_rdata <= rdata_d;
      group1_irq <= irq_d;
    end
  end

  // Checks on the status, mask and read paths.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // A one written outside test mode clears a flag that sees no new event.
  w1c_clear_a: assert property (
    (wr_status && !test_mode && !soft_rst) ##0
    (reg_wdata[3] && !events.async_rx_verified)
    |=> !status_q[3])
    else $error("status bit 3 not cleared by write of one");

  // A zero written outside test mode keeps a set flag.
  w0_keep_a: assert property (
    (wr_status && !test_mode && !soft_rst && status_q[12] && !reg_wdata[12])
    |=> status_q[12])
    else $error("status bit 12 lost on write of zero");

  // A software reset empties status and mask.
  soft_reset_a: assert property (
    soft_rst |=> (status_q == 32'h0000_0000) && (mask_q == 32'h0000_0000))
    else $error("software reset left state behind");

  // A test-mode write with no event loads the flags by the next edge.
  test_load_a: assert property (
    (wr_status && test_mode && !soft_rst && (32'(events) == 32'h0000_0000))
    |=> status_q == ($past(reg_wdata) & group1_irq_pkg::EVENT_BITS))
    else $error("test mode write did not load status");

  // Group-zero summary returns the input level on a status read.
  grp0_view_a: assert property (
    (reg_rd && hit_status)
    |=> reg_rdata[1] == $past(group0_pending))
    else $error("group-zero summary wrong on read");

  // Group-one summary tracks the stored flags outside test mode.
  grp1_view_a: assert property (
    (reg_rd && hit_status && !test_mode)
    |=> reg_rdata[2] == ($past(status_q) != 32'h0000_0000))
    else $error("group-one summary wrong on read");

  // The receive verify event sets bit 3 on the next edge, clear or not.
  event_set_a: assert property (
    (!soft_rst && events.async_rx_verified) |=> status_q[3])
    else $error("receive verify event lost");

  // Set wins over a simultaneous clear for the transmit done flag.
  set_wins_a: assert property (
    (!soft_rst && events.async_bulk_tx_done && wr_status && reg_wdata[29])
    |=> status_q[29])
    else $error("transmit done lost against clear");

  // The interrupt follows enabled flags and the routing bit one cycle later.
  irq_route_a: assert property (
    !soft_rst |=> group1_irq ==
      ($past(mask_q[2]) && ($past(status_q & mask_q) != 32'h0000_0000)))
    else $error("interrupt pin does not match masked flags");

  // With routing off the pin is low at the next edge.
  route_off_a: assert property (
    !mask_q[2] && !wr_mask |=> !group1_irq)
    else $error("interrupt raised with routing disabled");

  // Reserved positions never hold a one.
  reserved_zero_a: assert property (
    (status_q & ~group1_irq_pkg::EVENT_BITS) == 32'h0000_0000)
    else $error("reserved status bit set");

  // Read data appear only in the cycle after a read strobe.
  rdata_idle_a: assert property (
    !reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data present without a read strobe");

  // The checks below repeat the rules bit by bit and path by path.
  // They cost little, and a failure points at one flag or one field instead of the whole word.

  // Read data come back zero for any address outside the three registers.
  unmapped_read_a: assert property (
    (reg_rd && !hit_status && !hit_mask && !hit_diagnostics)
    |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped read returned data");

  // Mask reads return the stored enables unchanged.
  mask_read_a: assert property (
    (reg_rd && hit_mask) |=> reg_rdata == $past(mask_q))
    else $error("mask read differs from stored enables");

  // Diagnostics reads return the stored test control bit.
  test_ctrl_read_a: assert property (
    (reg_rd && hit_diagnostics) |=> reg_rdata == $past(diagnostics_q))
    else $error("diagnostics read differs from stored value");

  // The diagnostics register never holds more than its defined bit.
  test_ctrl_rsv_a: assert property (
    (diagnostics_q & ~group1_irq_pkg::DIAGNOSTICS_BITS) == 32'h0000_0000)
    else $error("reserved diagnostics bit set");

  // A status read shows exactly the stored flags at the event positions.
  status_read_a: assert property (
    (reg_rd && hit_status)
    |=> (reg_rdata & group1_irq_pkg::EVENT_BITS) == $past(status_q))
    else $error("status read differs from stored flags");

  // Only the stored flags and the two summaries can ever show on a status read.
  reserved_read_a: assert property (
    (reg_rd && hit_status)
    |=> (reg_rdata & ~group1_irq_pkg::EVENT_BITS
      & ~(32'h0000_0001 << group1_irq_pkg::GRP0_SUM_BIT)
      & ~(32'h0000_0001 << group1_irq_pkg::GRP1_SUM_BIT)) == 32'h0000_0000)
    else $error("reserved bit visible on status read");

  // Bit 1 keeps following the group-zero input in test mode; software cannot write it.
  grp0_test_a: assert property (
    (reg_rd && hit_status && test_mode)
    |=> reg_rdata[group1_irq_pkg::GRP0_SUM_BIT] == $past(group0_pending))
    else $error("group-zero summary wrong in test mode");

  // A test-mode write stores the summary override from bit 2 of the data.
  sum1_store_a: assert property (
    (wr_status && test_mode && !soft_rst)
    |=> sum1_test_q == $past(reg_wdata[group1_irq_pkg::GRP1_SUM_BIT]))
    else $error("summary override not stored");

  // In test mode bit 2 reads back the stored override, not the live summary.
  grp1_test_view_a: assert property (
    (reg_rd && hit_status && test_mode)
    |=> reg_rdata[group1_irq_pkg::GRP1_SUM_BIT] == $past(sum1_test_q))
    else $error("summary override not read back");

  // In test mode a write replaces the flags; events of that cycle still add in.
  test_write_a: assert property (
    (wr_status && test_mode && !soft_rst)
    |=> status_q == (($past(reg_wdata) | $past(event_vec)) & group1_irq_pkg::EVENT_BITS))
    else $error("test mode write did not replace the flags");

  // The test mode bit follows the value written to the diagnostics register.
  test_enable_a: assert property (
    (wr_diagnostics && !soft_rst)
    |=> test_mode == $past(reg_wdata[group1_irq_pkg::DIRECT_TEST_BIT]))
    else $error("test mode bit not loaded");

  // A software reset leaves test mode, so software never stays stuck in it.
  soft_test_off_a: assert property (
    soft_rst |=> !test_mode)
    else $error("software reset left test mode on");

  // A software reset drops the interrupt pin on the next edge.
  soft_irq_off_a: assert property (
    soft_rst |=> !group1_irq)
    else $error("interrupt pin high after software reset");

  // Changing the mask never alters the flags; masking only hides them from the pin.
  mask_keeps_flags_a: assert property (
    (wr_mask && !soft_rst && (event_vec == 32'h0000_0000))
    |=> status_q == $past(status_q))
    else $error("mask write changed the status flags");

  // With no enabled flag up the pin is low on the next edge.
  irq_idle_a: assert property (
    ((status_q & mask_q) == 32'h0000_0000) |=> !group1_irq)
    else $error("interrupt pin high with no enabled flag");

  // Per-bit checks, one copy for each event position and for each mask position.
  // Each copy watches one bit only, so a failing check names the flag directly.
  for (genvar b = 0; b < 32; b++) begin : g_bit_chk
    if (group1_irq_pkg::EVENT_BITS[b]) begin : g_event
      // The event sets its flag at the next edge, even against a clear.
      flag_set_a: assert property (
        (!soft_rst && event_vec[b]) |=> status_q[b])
        else $error("status flag not set by its event");

      // A one written outside test mode clears the flag when no event comes with it.
      flag_clear_a: assert property (
        (wr_status && !test_mode && !soft_rst && reg_wdata[b] && !event_vec[b])
        |=> !status_q[b])
        else $error("status flag not cleared by a write of one");

      // With no event, status write or reset in a cycle the flag keeps its value.
      flag_hold_a: assert property (
        (!soft_rst && !event_vec[b] && !wr_status)
        |=> status_q[b] == $past(status_q[b]))
        else $error("status flag changed without a cause");

      // A test-mode write loads the flag from the data, or from a coincident event.
      flag_load_a: assert property (
        (wr_status && test_mode && !soft_rst)
        |=> status_q[b] == ($past(reg_wdata[b]) || $past(event_vec[b])))
        else $error("status flag not loaded in test mode");

      // An enabled flag drives the pin on the next edge while routing is on.
      flag_irq_a: assert property (
        (!soft_rst && status_q[b] && mask_q[b] && mask_q[group1_irq_pkg::PIN_ROUTE_BIT])
        |=> group1_irq)
        else $error("enabled status flag did not reach the pin");
    end
    if (group1_irq_pkg::MASK_BITS[b]) begin : g_mask
      // A mask write stores every defined enable bit as written.
      mask_load_a: assert property (
        (wr_mask && !soft_rst) |=> mask_q[b] == $past(reg_wdata[b]))
        else $error("mask bit not stored as written");
    end else begin : g_mask_rsv
      // Undefined mask positions never hold a one, whatever software writes.
      mask_rsv_a: assert property (
        !mask_q[b])
        else $error("reserved mask bit set");
    end
  end

endmodule

`default_nettype wire

// file: hw/group1_irq_pkg.sv
// Register map, field layout and event carrier for the group-one interrupt status block.
package group1_irq_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Byte addresses of the registers reached over the plain register port.
  localparam logic [7:0] STATUS_OFS = 8'h18;
  localparam logic [7:0] MASK_OFS = 8'h1C;
  localparam logic [7:0] DIAGNOSTICS_OFS = 8'h30;

  // Bit positions of the summary, routing and test fields.
  localparam int GRP0_SUM_BIT = 1;
  localparam int GRP1_SUM_BIT = 2;
  localparam int PIN_ROUTE_BIT = 2;
  localparam int DIRECT_TEST_BIT = 0;

  // Status bits that hardware events can set; all others are reserved.
  localparam logic [31:0] EVENT_BITS = 32'hE77F_7D58;
  // Writable mask bits: one enable per event bit plus the pin routing enable.
  localparam logic [31:0] MASK_BITS = 32'hE77F_7D5C;
  localparam logic [31:0] DIAGNOSTICS_BITS = 32'h0000_0001;

  localparam logic [31:0] STATUS_RST = 32'h0000_0000;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  localparam logic [31:0] DIAGNOSTICS_RST = 32'h0000_0000;

  // One-cycle event pulses, laid out at their status bit positions.
  typedef struct packed {
    logic rx_block_count_error;
    logic async_bulk_tx_failed;
    logic async_bulk_tx_done;
    logic [1:0] unused_28_27;
    logic tx_block_count_error;
    logic early_iso_go_error;
    logic host_access_blocked;
    logic unused_23;
    logic selfid_partial_purge;
    logic selfid_period_done;
    logic bcast_partial_purge;
    logic bcast_packet_confirmed;
    logic async_ctrl_partial_purge;
    logic async_ctrl_packet_confirmed;
    logic video_partial_purge;
    logic unused_15;
    logic iso_partial_purge;
    logic handshake_timeout;
    logic async_bulk_partial_purge;
    logic overlapping_access_error;
    logic host_fifo_access_error;
    logic unused_9;
    logic video_release_time_hit;
    logic unused_7;
    logic video_rx_verified;
    logic unused_5;
    logic iso_rx_verified;
    logic async_rx_verified;
    logic [2:0] unused_2_0;
  } event_type;

endpackage

// file: tb/host_model.sv
// Host processor model that drives the plain register port of the status block.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic core_clk,
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  // The bus starts idle with no strobe raised.
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // One write cycle; released lines show the inverse so stale values never look valid.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_addr <= ~a;
    reg_wdata <= ~d;
    reg_wr <= 1'b0;
  endtask
  // One read cycle; the bench catches the data in the following cycle.
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_addr <= ~a;
    reg_rd <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the group-one interrupt status block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [31:0] EV = group1_irq_pkg::EVENT_BITS;
  localparam logic [7:0] ST = group1_irq_pkg::STATUS_OFS;
  localparam logic [7:0] MK = group1_irq_pkg::MASK_OFS;
  localparam logic [7:0] DG = group1_irq_pkg::DIAGNOSTICS_OFS;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic soft_rst = 1'b0;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  group1_irq_pkg::event_type events = '0;
  logic group0_pending = 1'b0;
  logic group1_irq;
  logic rd_pend = 1'b0;
  logic [31:0] exp_q[$];
  logic [31:0] w;
  int fails = 0;
  int checks_done = 0;

  // The clock toggles every half period.
  always #12.5 core_clk = ~core_clk;

  host_model i_host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd));
  extended_interrupt_status i_dut (.core_clk(core_clk), .rst(rst), .soft_rst(soft_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .events(events),
    .group0_pending(group0_pending), .group1_irq(group1_irq));

  task automatic cmp(input logic [31:0] e, input logic [31:0] a);
    checks_done++;
    if (a !== e) begin
      fails++;
      $display("FAIL t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask

  function automatic logic [31:0] g0();
    return {30'h0, group0_pending, 1'b0};
  endfunction

  // The expected word is noted before the strobe goes out.
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    i_host.rd(a);
  endtask

  task automatic pulse(input logic [31:0] v);
    @(posedge core_clk);
    events <= group1_irq_pkg::event_type'(v);
    @(posedge core_clk);
    events <= '0;
  endtask

  // The pin is registered, so it is looked at one edge after the state settles.
  task automatic irq(input logic e);
    @(posedge core_clk);
    #1;
    cmp({31'h0, e}, {31'h0, group1_irq});
  endtask

  task automatic results;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Read data stand only in the cycle after the strobe.
  always @(posedge core_clk) rd_pend <= reg_rd;

  // Compares each read result with the oldest note, away from the sampling edge.
  always @(negedge core_clk) begin
    if (rd_pend) begin
      cmp(exp_q.pop_front(), reg_rdata);
    end
  end

  // A hang is cut short long after the sequence should have ended.
  initial begin
    repeat (5000) @(posedge core_clk);
    fails++;
    results();
  end

  // Main sequence.
  initial begin
    void'($urandom(32'h2d44_9c41));
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    rd(ST, 32'h0000_0000);
    rd(MK, 32'h0000_0000);
    rd(DG, 32'h0000_0000);
    i_host.wr(MK, 32'hFFFF_FFFF);
    i_host.wr(8'h40, 32'h0000_0000);
    rd(MK, group1_irq_pkg::MASK_BITS);
    rd(8'h40, 32'h0000_0000);
    pulse(~EV);
    rd(ST, g0());
    $display("test reset_map done");
    for (int i = 0; i < 32; i++) begin
      if (EV[i]) begin
        group0_pending <= 1'($urandom);
        pulse(32'h1 << i);
        irq(1'b1);
        rd(ST, (32'h1 << i) | 32'h4 | g0());
        i_host.wr(ST, 32'h1 << i);
        rd(ST, g0());
      end
    end
    $display("test events done");
    pulse(32'h0000_0008);
    i_host.wr(ST, 32'h0000_0006);
    rd(ST, 32'h0000_000C | g0());
    i_host.wr(MK, group1_irq_pkg::MASK_BITS & ~32'h0000_0008);
    irq(1'b0);
    i_host.wr(MK, 32'h0000_0008);
    irq(1'b0);
    i_host.wr(MK, group1_irq_pkg::MASK_BITS);
    irq(1'b1);
    i_host.wr(ST, 32'h0000_0008);
    pulse(32'h0000_1008);
    i_host.wr(ST, 32'h0000_0008);
    rd(ST, 32'h0000_1004 | g0());
    // Event and clear land on the same edge; the event must win.
    fork
      pulse(32'h2000_0000);
      i_host.wr(ST, 32'h2000_1000);
    join
    rd(ST, 32'h2000_0004 | g0());
    i_host.wr(ST, 32'h2000_0000);
    $display("test masking done");
    i_host.wr(DG, 32'h1 << group1_irq_pkg::DIRECT_TEST_BIT);
    w = $urandom | 32'h0000_000C;
    i_host.wr(ST, w);
    rd(ST, (w & EV) | 32'h4 | g0());
    rd(DG, group1_irq_pkg::DIAGNOSTICS_BITS);
    i_host.wr(ST, 32'h0000_0008);
    rd(ST, 32'h0000_0008 | g0());
    @(posedge core_clk);
    soft_rst <= 1'b1;
    @(posedge core_clk);
    soft_rst <= 1'b0;
    rd(ST, g0());
    rd(MK, 32'h0000_0000);
    rd(DG, 32'h0000_0000);
    $display("test direct_mode done");
    repeat (3) @(posedge core_clk);
    results();
  end
endmodule
`default_nettype wire
